// ### wdro_top.sv
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module wdro_top #(
   parameter int RST_LEN = wdro_pkg::RST_LEN_DEF
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Reset input pin, two-way
   input wire logic reset_in_pin_i,
   output logic reset_in_pin_o,
   output logic reset_in_pin_oe,
   // Reset powerdown pin
   input wire logic reset_powerdown_pin_i,
   output logic rpd_pullup_en,
   output logic rpd_pulldown_en,
   // Reset outputs and interrupt
   output logic reset_out_pin,
   output logic sys_reset,
   output logic irq
);
   // Reset sequence states
   typedef enum logic {ST_RUN, ST_RST} wdro_state_type;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   wdro_state_type state; // Sequence state
   wdro_state_type next_state; // Next sequence state
   wdro_pkg::wdro_ctrl_type ctrl; // Control register
   wdro_pkg::wdro_scfg_type scfg; // System config
   logic [15:0] cnt; // Watchdog counter
   logic [6:0] pre; // Prescaler
   logic [7:0] rst_cnt; // Reset stretch counter
   logic drive_kind; // Reset may drive pin
   logic [2:0] ist; // Interrupt status
   logic [2:0] imsk; // Interrupt mask
   logic ap_wr; // Write data phase pending
   logic [7:0] ap_addr; // Latched address
   logic [4:0] next_cause; // Cause of entry

   // Bus address phase accepted
   logic valid;
   assign valid = hsel & hready & htrans[1];

   // Data phase write strobes
   logic wr_ctrl, wr_scfg, wr_cmd, wr_ist, wr_imsk;
   assign wr_ctrl = ap_wr && ap_addr == wdro_pkg::ADDR_CTRL;
   assign wr_scfg = ap_wr && ap_addr == wdro_pkg::ADDR_SCFG;
   assign wr_cmd = ap_wr && ap_addr == wdro_pkg::ADDR_CMD;
   assign wr_ist = ap_wr && ap_addr == wdro_pkg::ADDR_IST;
   assign wr_imsk = ap_wr && ap_addr == wdro_pkg::ADDR_IMSK;

   // Commands only act while running
   logic run, svc, end_init_instruction, dis, soft_reset_instruction;
   assign run = state == ST_RUN;
   assign svc = run && wr_cmd && hwdata[wdro_pkg::CMD_SERVICE];
   assign end_init_instruction = run && wr_cmd && hwdata[wdro_pkg::CMD_END_INIT_INSTRUCTION];
   assign dis = run && wr_cmd && hwdata[wdro_pkg::CMD_DISABLE];
   assign soft_reset_instruction = run && wr_cmd && hwdata[wdro_pkg::CMD_SOFT_RESET_INSTRUCTION];

   // Pin low from outside; own drive masked
   // to avoid holding ourselves in reset
   logic ext_low, short_rst, long_rst;
   assign ext_low = !reset_in_pin_i && !reset_in_pin_oe;
   assign long_rst = ext_low && !reset_powerdown_pin_i;
   assign short_rst = ext_low && reset_powerdown_pin_i;

   // Prescaler tick
   logic tick, wd_on, ovf;
   assign tick = ctrl.prescale_select ? (pre == wdro_pkg::PRE_LAST) : pre[0];
   assign wd_on = !ctrl.wd_off;
   assign ovf = run && wd_on && tick && !svc && cnt == wdro_pkg::CNT_MAX;

   // Any cause that starts a reset sequence
   logic ent;
   assign ent = run && (ovf || soft_reset_instruction || ext_low);

   // Cause selection, watchdog first
   always_comb
   begin
      next_cause = 5'h00;
      if (ovf)
      begin
         next_cause = wdro_pkg::CAUSE_WDT;
      end
      else if (soft_reset_instruction)
      begin
         next_cause = wdro_pkg::CAUSE_SOFT;
      end
      else if (long_rst)
      begin
         next_cause = wdro_pkg::CAUSE_LONG;
      end
      else if (short_rst)
      begin
         next_cause = wdro_pkg::CAUSE_SHORT;
      end
   end

   // Next sequence state
   always_comb
   begin
      next_state = state;
      case (state)
         ST_RUN:
         begin
            if (ent)
            begin
               next_state = ST_RST;
            end
         end
         ST_RST:
         begin
            // Held while pin stays low from outside
            if (!ext_low && rst_cnt == 8'(RST_LEN - 1))
            begin
               next_state = ST_RUN;
            end
         end
         default:
         begin
            next_state = ST_RUN;
         end
      endcase
   end

   // Sequence state and stretch counter
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= ST_RUN;
         rst_cnt <= 8'h00;
      end
      else
      begin
         state <= next_state;
         if (state == ST_RUN || ext_low)
         begin
            rst_cnt <= 8'h00;
         end
         else
         begin
            rst_cnt <= rst_cnt + 8'h01;
         end
      end
   end

   // Whether the reset may be driven back out
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         drive_kind <= 1'b0;
      end
      else if (ent)
      begin
         drive_kind <= ovf || soft_reset_instruction || short_rst;
      end
      else if (!run && long_rst)
      begin
         // Asynchronous reset is never driven
         drive_kind <= 1'b0;
      end
   end

   // Control register; cause survives internal reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl <= wdro_pkg::CTRL_RST;
         ctrl.cause <= wdro_pkg::CAUSE_POR;
      end
      else if (ent)
      begin
         ctrl <= wdro_pkg::CTRL_RST;
         ctrl.cause <= next_cause;
      end
      else if (!run)
      begin
         // Pin held low long enough escalates
         if (long_rst)
         begin
            ctrl.cause <= wdro_pkg::CAUSE_LONG;
         end
      end
      else
      begin
         if (wr_ctrl)
         begin
            ctrl.reload_byte <= hwdata[15:8];
            ctrl.prescale_select <= hwdata[0];
         end
         if (dis && !ctrl.init_done)
         begin
            ctrl.wd_off <= 1'b1;
         end
         if (end_init_instruction)
         begin
            ctrl.init_done <= 1'b1;
            ctrl.cause <= 5'h00;
         end
      end
   end

   // System config, cleared only by power-on
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         scfg <= '0;
      end
      else if (wr_scfg)
      begin
         scfg <= hwdata[1:0];
      end
   end

   // Prescaler restarts with each run
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pre <= 7'h00;
      end
      else if (next_state != ST_RUN)
      begin
         pre <= 7'h00;
      end
      else
      begin
         pre <= pre + 7'h01;
      end
   end

   // Watchdog counter; service beats the tick
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt <= 16'h0000;
      end
      else if (next_state != ST_RUN)
      begin
         cnt <= 16'h0000;
      end
      else if (svc)
      begin
         cnt <= {ctrl.reload_byte, 8'h00};
      end
      else if (wd_on && tick)
      begin
         cnt <= cnt + 16'h0001;
      end
   end

   // Pins and reset outputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         reset_out_pin <= 1'b0;
         reset_in_pin_o <= 1'b0;
         reset_in_pin_oe <= 1'b0;
         rpd_pullup_en <= 1'b0;
         rpd_pulldown_en <= 1'b0;
         sys_reset <= 1'b0;
      end
      else
      begin
         if (ent)
         begin
            reset_out_pin <= 1'b0;
         end
         else if (end_init_instruction)
         begin
            reset_out_pin <= 1'b1;
         end
         reset_in_pin_o <= 1'b0;
         reset_in_pin_oe <= scfg.bidir_reset_enable && !run && drive_kind;
         rpd_pullup_en <= scfg.powerdown_config && next_state == ST_RUN;
         rpd_pulldown_en <= !reset_in_pin_i;
         sys_reset <= next_state == ST_RST;
      end
   end

   // Interrupt status, set wins over clear
   logic [2:0] ev;
   assign ev = {end_init_instruction, svc, ovf};
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ist <= 3'h0;
         imsk <= 3'h0;
         irq <= 1'b0;
      end
      else
      begin
         if (wr_ist)
         begin
            ist <= (ist & ~hwdata[2:0]) | ev;
         end
         else
         begin
            ist <= ist | ev;
         end
         if (wr_imsk)
         begin
            imsk <= hwdata[2:0];
         end
         irq <= |(ist & imsk);
      end
   end

   // Read mux for the address phase
   logic [31:0] rd_mux;
   always_comb
   begin
      case (haddr[7:0])
         wdro_pkg::ADDR_CTRL: rd_mux = {16'h0000, ctrl};
         wdro_pkg::ADDR_SCFG: rd_mux = {30'h0, scfg};
         wdro_pkg::ADDR_CNT: rd_mux = {16'h0000, cnt};
         wdro_pkg::ADDR_IST: rd_mux = {29'h0, ist};
         wdro_pkg::ADDR_IMSK: rd_mux = {29'h0, imsk};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Bus slave: zero wait, always OKAY
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ap_wr <= 1'b0;
         ap_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         ap_wr <= valid && hwrite;
         if (valid)
         begin
            ap_addr <= haddr[7:0];
         end
         if (valid && !hwrite)
         begin
            hrdata <= rd_mux;
         end
      end
   end

   // Timeout bound, reload ffh, divide by 2
   localparam int TO_LO = 1;
   localparam int TO_HI = 514;

   sequence s_enter;
      ent ##1 !run;
   endsequence
   sequence s_leave;
      (state == ST_RST) ##1 run;
   endsequence

   a_enable_after_rst: assert property (s_leave |-> wd_on)
      else $error("watchdog not enabled after reset");
   a_disable_locked: assert property ((dis && ctrl.init_done && !ent) |=> $stable(ctrl.wd_off))
      else $error("disable accepted after end of init");
   a_ovf_reset: assert property (ovf |-> s_enter ##0 sys_reset)
      else $error("overflow did not reset");
   a_ovf_reset_out_pin: assert property (ovf |=> !reset_out_pin [*2])
      else $error("reset out not low on watchdog reset");
   a_cause_wdt: assert property (ovf |=> ctrl.cause == wdro_pkg::CAUSE_WDT)
      else $error("watchdog cause not recorded");
   a_end_init_instruction_clear: assert property ((end_init_instruction && !ent) |=> ctrl.cause == 5'h00)
      else $error("cause flags not cleared");
   a_cnt_hold: assert property ((run && !svc && !(wd_on && tick) && !ent)
      |=> $stable(cnt))
      else $error("counter moved without tick");
   a_service_load: assert property ((svc && !ent)
      |=> cnt == {$past(ctrl.reload_byte), 8'h00})
      else $error("service load wrong");
   a_timeout_ff: assert property ((svc && !ent && wd_on && ctrl.reload_byte == 8'hff
      && !ctrl.prescale_select) |-> ##[TO_LO:TO_HI] (ovf || svc || !run || wr_ctrl))
      else $error("timeout too long");
   a_bidir_drive: assert property (((ovf || soft_reset_instruction) && scfg.bidir_reset_enable && !wr_scfg)
      |=> ##1 reset_in_pin_oe)
      else $error("reset in not driven");
   a_end_init_instruction_reset_out_pin: assert property ((end_init_instruction && !ent) |=> reset_out_pin)
      else $error("reset out not released");
   a_pullup: assert property ((next_state == ST_RUN && scfg.powerdown_config)
      |=> rpd_pullup_en)
      else $error("pull-up not enabled");
   a_pulldown: assert property (!reset_in_pin_i |=> rpd_pulldown_en)
      else $error("pull-down not enabled");
   a_long_cause: assert property (long_rst |=> !run && ctrl.cause == wdro_pkg::CAUSE_LONG
      || ctrl.cause == wdro_pkg::CAUSE_WDT || ctrl.cause == wdro_pkg::CAUSE_SOFT)
      else $error("asynchronous reset not taken");
   a_short_seq: assert property ((run && short_rst && !ovf && !soft_reset_instruction)
      |=> ctrl.cause == wdro_pkg::CAUSE_SHORT)
      else $error("short reset cause wrong");
   a_svc_low: assert property ((svc && !ent) |=> cnt[7:0] == 8'h00)
      else $error("low byte not cleared");
endmodule : wdro_top
`default_nettype wire

// ### wdro_pkg.sv
`default_nettype none
package wdro_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SCFG = 8'h04;
   localparam logic [7:0] ADDR_CMD = 8'h08;
   localparam logic [7:0] ADDR_CNT = 8'h0c;
   localparam logic [7:0] ADDR_IST = 8'h10;
   localparam logic [7:0] ADDR_IMSK = 8'h14;
   // Command register bits
   localparam int CMD_SERVICE = 0;
   localparam int CMD_END_INIT_INSTRUCTION = 1;
   localparam int CMD_DISABLE = 2;
   localparam int CMD_SOFT_RESET_INSTRUCTION = 3;
   // One-hot reset cause codes
   localparam logic [4:0] CAUSE_WDT = 5'h01;
   localparam logic [4:0] CAUSE_SOFT = 5'h02;
   localparam logic [4:0] CAUSE_SHORT = 5'h04;
   localparam logic [4:0] CAUSE_LONG = 5'h08;
   localparam logic [4:0] CAUSE_POR = 5'h10;
   // Interrupt status bits
   localparam int IRQ_OVF = 0;
   localparam int IRQ_SVC = 1;
   localparam int IRQ_END_INIT_INSTRUCTION = 2;
   localparam int IRQ_W = 3;
   // Prescaler and counter figures
   localparam logic [6:0] PRE_LAST = 7'h7f;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam int RST_LEN_DEF = 16;
   // Timeout with reload ffh, divide by 2
   localparam int TOUT_FF_TICKS = 256;
   localparam int TOUT_FF_CYC = TOUT_FF_TICKS * 2;
   // Control register layout, low half-word
   typedef struct packed {
      logic [7:0] reload_byte;
      logic init_done;
      logic [4:0] cause;
      logic wd_off;
      logic prescale_select;
   } wdro_ctrl_type;
   // System configuration layout
   typedef struct packed {
      logic powerdown_config;
      logic bidir_reset_enable;
   } wdro_scfg_type;
   localparam wdro_ctrl_type CTRL_RST = '{8'h00, 1'b0, 5'h00, 1'b0, 1'b0};
endpackage : wdro_pkg
`default_nettype wire

// ### wdro_rst_model.sv
`timescale 1ns/1ps
`default_nettype none
// Board reset parts: pulled-up reset pin, RC on the powerdown pin
module wdro_rst_model #(
   parameter int CAP = 8
) (
   // Clock
   input wire logic clk,
   // Device drive and pulls
   input wire logic pin_oe,
   input wire logic pin_o,
   input wire logic pd_en,
   // Push button
   input wire logic button_low,
   // Pin levels
   output logic reset_in_lvl,
   output logic rpd_lvl
);
   // Capacitor charge, full after power-up
   int charge = CAP;
   // Wired low beats the pin pull-up
   assign reset_in_lvl = !(button_low || (pin_oe && !pin_o));
   // Slow threshold, so short pulses never discharge it
   assign rpd_lvl = (charge > CAP / 2);
   // Internal pull-down drains, external resistor recharges
   always @(posedge clk)
   begin
      if (pd_en && charge > 0)
      begin
         charge <= charge - 1;
      end
      else if (!pd_en && charge < CAP)
      begin
         charge <= charge + 1;
      end
   end
endmodule : wdro_rst_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // Clock, reset and bus
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, button_low = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0;
   logic hreadyout, hresp, pin_i, pin_o, pin_oe, rpd_i, pu_en, pd_en;
   logic rst_out, sys_reset, irq;
   int miscompares = 0, cmp_count = 0;
   always #4 hclk = !hclk;
   // Short stretch keeps internal resets brief
   wdro_top #(.RST_LEN(2)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .reset_in_pin_i(pin_i),
      .reset_in_pin_o(pin_o), .reset_in_pin_oe(pin_oe),
      .reset_powerdown_pin_i(rpd_i), .rpd_pullup_en(pu_en),
      .rpd_pulldown_en(pd_en), .reset_out_pin(rst_out),
      .sys_reset(sys_reset), .irq(irq));
   wdro_rst_model MDL (.clk(hclk), .pin_oe(pin_oe), .pin_o(pin_o), .pd_en(pd_en),
      .button_low(button_low), .reset_in_lvl(pin_i), .rpd_lvl(rpd_i));
   // Verdict and end of run
   task automatic wrap_up();
      if (miscompares == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up
   // One comparison
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Bounded wait for a level on sys_reset, returns edges spent
   task automatic wait_rst(input logic lvl, input int lim, output int n);
      n = 0;
      while (sys_reset !== lvl)
      begin
         @(posedge hclk);
         n++;
         if (n > lim)
         begin
            miscompares++;
            wrap_up();
         end
      end
   endtask : wait_rst
   // Edge on which hready is high, bounded
   task automatic ready();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
         n++;
         if (n > 50)
         begin
            miscompares++;
            wrap_up();
         end
         @(posedge hclk);
      end
   endtask : ready
   // Single word transfer; read data lands in rd
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      ready();
      hsel <= 0;
      htrans <= 2'b00;
      hwdata <= d;
      ready();
      rd = hrdata;
   endtask : bus
   // Internal reset runs out, then cause is read
   task automatic cause_is(input logic [4:0] c);
      int n;
      wait_rst(1'b0, 100, n);
      bus(0, wdro_pkg::ADDR_CTRL, 0);
      check({27'h0, rd[6:2]}, {27'h0, c});
   endtask : cause_is
   // Power-on state, running counter, unmapped read
   task automatic t_reset_state();
      logic [31:0] c0;
      check({31'h0, rst_out}, 0);
      check({31'h0, hresp}, 0);
      bus(0, wdro_pkg::ADDR_CTRL, 0);
      check({27'h0, rd[6:2]}, {27'h0, wdro_pkg::CAUSE_POR});
      check({31'h0, rd[1]}, 0);
      bus(0, wdro_pkg::ADDR_CNT, 0);
      c0 = rd;
      bus(0, 8'h3c, 0);
      check(rd, 0);
      bus(0, wdro_pkg::ADDR_CNT, 0);
      check({31'h0, rd != c0}, 1);
   endtask : t_reset_state
   // Divide by 128: 256 cycles between reads give two ticks
   task automatic t_div128();
      logic [31:0] c0;
      bus(1, wdro_pkg::ADDR_CTRL, 32'h1);
      bus(1, wdro_pkg::ADDR_CMD, 32'h1);
      bus(0, wdro_pkg::ADDR_CNT, 0);
      c0 = rd;
      repeat (254) @(posedge hclk);
      bus(0, wdro_pkg::ADDR_CNT, 0);
      check(rd - c0, 2);
      bus(1, wdro_pkg::ADDR_CTRL, 32'h0);
   endtask : t_div128
   // Reload ffh timeout, watchdog reset, pin drive, interrupt
   task automatic t_timeout();
      int n;
      bus(1, wdro_pkg::ADDR_SCFG, 32'h1);
      bus(1, wdro_pkg::ADDR_CMD, 32'h2);
      @(posedge hclk);
      check({31'h0, rst_out}, 1);
      bus(1, wdro_pkg::ADDR_CTRL, 32'hff00);
      bus(1, wdro_pkg::ADDR_CMD, 32'h1);
      bus(0, wdro_pkg::ADDR_CNT, 0);
      check({24'h0, rd[15:8]}, 32'hff);
      check({31'h0, rd[7:0] < 8'h08}, 1);
      wait_rst(1'b1, 1000, n);
      n = n + 2;
      check({31'h0, n >= wdro_pkg::TOUT_FF_CYC - 4}, 1);
      check({31'h0, n <= wdro_pkg::TOUT_FF_CYC + 4}, 1);
      check({31'h0, rst_out}, 0);
      repeat (2) @(posedge hclk);
      check({30'h0, pin_oe, pin_i}, 32'h2);
      cause_is(wdro_pkg::CAUSE_WDT);
      bus(0, wdro_pkg::ADDR_IST, 0);
      check({29'h0, rd[2:0]}, 32'h7);
      check({31'h0, irq}, 0);
      bus(1, wdro_pkg::ADDR_IMSK, 32'h1);
      repeat (2) @(posedge hclk);
      check({31'h0, irq}, 1);
      bus(1, wdro_pkg::ADDR_IST, 32'h7);
      repeat (2) @(posedge hclk);
      check({31'h0, irq}, 0);
   endtask : t_timeout
   // Software reset, then disable before end of init
   task automatic t_soft();
      int n;
      bus(1, wdro_pkg::ADDR_CMD, 32'h8);
      wait_rst(1'b1, 10, n);
      cause_is(wdro_pkg::CAUSE_SOFT);
      bus(1, wdro_pkg::ADDR_CMD, 32'h4);
      bus(0, wdro_pkg::ADDR_CTRL, 0);
      check({31'h0, rd[1]}, 1);
   endtask : t_soft
   // Button pulses: short and long, with powerdown pulls
   task automatic t_pins(input int len, input logic [4:0] c);
      int n;
      bus(1, wdro_pkg::ADDR_SCFG, 32'h2);
      repeat (2) @(posedge hclk);
      check({31'h0, pu_en}, 1);
      @(posedge hclk);
      button_low <= 1;
      repeat (2) @(posedge hclk);
      check({31'h0, pd_en}, 1);
      repeat (len) @(posedge hclk);
      button_low <= 0;
      cause_is(c);
      check({31'h0, pu_en}, 1);
      repeat (12) @(posedge hclk);
   endtask : t_pins
   // End of init: reset out released, causes cleared, disable refused
   task automatic t_end_init_instruction();
      bus(1, wdro_pkg::ADDR_CMD, 32'h2);
      @(posedge hclk);
      check({31'h0, rst_out}, 1);
      bus(1, wdro_pkg::ADDR_CMD, 32'h4);
      bus(0, wdro_pkg::ADDR_CTRL, 0);
      check({27'h0, rd[6:2]}, 0);
      check({31'h0, rd[1]}, 0);
   endtask : t_end_init_instruction
   // Main sequence
   initial
   begin
      repeat (5) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      t_reset_state();
      t_div128();
      t_timeout();
      t_soft();
      t_pins(1, wdro_pkg::CAUSE_SHORT);
      t_pins(10, wdro_pkg::CAUSE_LONG);
      t_end_init_instruction();
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
